// ===== include/lfw_pkg.sv
// Purpose: Constants and types shared by the LF wake-up timing and status block.
// Assumes: Registers sit on 32-bit Avalon-MM words; byte address is four times the index.
// Notes:   Timing figures are counted in LF oscillator cycles, one cycle being 3.3 us.

package lfw_pkg;

  // --------------------------------------------------------------------------
  // Register indices
  // --------------------------------------------------------------------------
  localparam int          ADDR_W        = 10;
  localparam logic [7:0]  IDX_SNIFF     = 8'hdc;
  localparam logic [7:0]  IDX_CARRIER   = 8'hdd;
  localparam logic [7:0]  IDX_FE_STATUS = 8'he1;
  localparam logic [7:0]  IDX_RX_BYTE   = 8'he2;
  localparam logic [7:0]  IDX_BIT_WIDTH = 8'hec;
  localparam logic [7:0]  IDX_STATE     = 8'hc8;
  localparam logic [7:0]  IDX_MODE      = 8'hf0;
  localparam logic [7:0]  IDX_IRQ_STAT  = 8'hf1;
  localparam logic [7:0]  IDX_IRQ_MASK  = 8'hf2;

  // --------------------------------------------------------------------------
  // Field layout and reset values
  // --------------------------------------------------------------------------
  localparam int          OVR_LSB       = 3;
  localparam int          OVR_W         = 5;
  localparam int          PRE_W         = 3;
  localparam int          CD_W          = 4;
  localparam int          PREVALID_BIT  = 4;
  localparam int          MODE_EN_BIT   = 0;
  localparam int          MODE_TRIM_BIT = 6;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [6:0]  WIDTH_MAX     = 7'h7f;

  // Raw front-end input order, also the synchroniser lane order.
  localparam int FE_W = 9;
  localparam int FE_AMP = 0;
  localparam int FE_BIAS = 1;
  localparam int FE_THRESH = 2;
  localparam int FE_OFS_TRIM = 3;
  localparam int FE_LPF_TRIM = 4;
  localparam int FE_CARRIER = 5;
  localparam int FE_OSC = 6;
  localparam int FE_SAMPLE = 7;
  localparam int FE_DATA = 8;

  // Interrupt status bits.
  localparam int IRQ_W = 4;
  localparam int IRQ_BYTE = 0;
  localparam int IRQ_PRE = 1;
  localparam int IRQ_ABORT = 2;
  localparam int IRQ_WAKE = 3;

  // --------------------------------------------------------------------------
  // Timing, in LF oscillator cycles
  // --------------------------------------------------------------------------
  localparam int LF_PERIOD_NS   = 3300;
  localparam int OVR_MULT       = 512;
  localparam int OVR_ADD        = 257;
  localparam int TICKS_PER_UNIT = 4;
  localparam int PRE_MULT       = 128;
  localparam int CD_MULT        = 8;
  localparam logic [2:0] PRE_RUN_SHORT = 3'h3;
  localparam logic [2:0] PRE_RUN_LONG  = 3'h5;
  localparam logic [2:0] HEAD_RUN      = 3'h3;
  localparam logic [2:0] LAST_BIT_IDX  = 3'h7;
  localparam int DIV_W          = 5;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_CARR = 5'b00010,
    S_PRE  = 5'b00100,
    S_HEAD = 5'b01000,
    S_DATA = 5'b10000
  } lfw_state_e;

endpackage : lfw_pkg

// ===== rtl/lfw_sync3.sv
// Purpose: Three-stage synchroniser with agreement filter for the front-end inputs.
// Assumes: Inputs are asynchronous to CLOCK.
// Notes:   A lane only moves once stages two and three agree.

`timescale 1ns/1ps

module lfw_sync3 #(
  parameter int W = lfw_pkg::FE_W
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } lfw_sync_s;

  lfw_sync_s    q;
  lfw_sync_s    d;
  logic [W-1:0] upd;

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_lane
      assign upd[gi] = (q.s2[gi] == q.s3[gi]) ? q.s2[gi] : q.stable[gi];
    end
  endgenerate

  always_comb begin
    d        = q;
    d.s1     = din;
    d.s2     = q.s1;
    d.s3     = q.s2;
    d.stable = upd;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.stable;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_sync_agree;
    (q.stable != $past(q.stable))
      |-> ((q.stable ^ $past(q.stable)) & ($past(q.s2) ^ $past(q.s3))) == '0;
  endproperty
  a_sync_agree: assert property (p_sync_agree) else $error("lane moved without agreement");

endmodule : lfw_sync3

// ===== rtl/lfw_rx_status.sv
// Purpose: LF wake-up receiver timing limits, front-end status and receive status.
// Assumes: Front-end pins are asynchronous; match inputs come from logic on CLOCK.
// Notes:   Avalon-MM slave with one wait state on every access.
//
// The Avalon-MM slave port is this design's own decision.

`timescale 1ns/1ps

module lfw_rx_status (
  input  wire logic                       CLOCK,
  input  wire logic                       RST,
  input  wire logic [lfw_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic                       AVS_READ,
  input  wire logic                       AVS_WRITE,
  input  wire logic [31:0]                AVS_WRITEDATA,
  input  wire logic [3:0]                 AVS_BYTEENABLE,
  output logic      [31:0]                AVS_READDATA,
  output logic                            AVS_WAITREQUEST,
  input  wire logic                       AMP_READY,
  input  wire logic                       BIAS_MONITOR,
  input  wire logic                       STRENGTH_THRESHOLD_OUT,
  input  wire logic                       SLICER_OFFSET_TRIM,
  input  wire logic                       SLICER_LPF_TRIM,
  input  wire logic                       CARRIER_OUT,
  input  wire logic                       LOWFREQ_OSCILLATOR_CLOCK,
  input  wire logic                       SAMPLE_STROBE,
  input  wire logic                       DATA_BIT,
  input  wire logic                       SYNC_MATCH,
  input  wire logic                       WAKE_MATCH,
  output logic                            IRQ
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    lfw_pkg::lfw_state_e           state;
    logic                          ack;
    logic [7:0]                    rdata;
    logic [7:0]                    sniff_lim;
    logic [4:0]                    cd_cfg;
    logic [7:0]                    mode;
    logic [lfw_pkg::IRQ_W-1:0]     irq_stat;
    logic [lfw_pkg::IRQ_W-1:0]     irq_mask;
    logic [7:0]                    rx_byte;
    logic [6:0]                    width_reg;
    logic [6:0]                    width_cnt;
    logic [15:0]                   ovr_cnt;
    logic [15:0]                   ph_cnt;
    logic [2:0]                    run;
    logic [2:0]                    bitn;
    logic [7:0]                    shift;
    logic                          last_bit;
    logic                          osc_q;
    logic                          samp_q;
    logic                          data_q;
    logic [lfw_pkg::DIV_W-1:0]     div;
    logic                          fl_ready;
    logic                          fl_sync;
    logic                          fl_wake;
    logic                          fl_head;
    logic                          fl_pre;
    logic                          fl_abort;
  } lfw_regs_s;

  lfw_regs_s                   q;
  lfw_regs_s                   d;
  logic [lfw_pkg::FE_W-1:0]    fe;
  logic [7:0]                  fe_vec;
  logic [7:0]                  state_vec;
  logic [7:0]                  rmux;
  logic [7:0]                  idx;
  logic                        req;
  logic                        acc;
  logic                        tick;
  logic                        s_edge;
  logic                        d_edge;
  logic                        smp_bit;
  logic                        sniffing;
  logic [15:0]                 ovr_lim;
  logic [15:0]                 pre_lim;
  logic [15:0]                 cd_lim;
  logic [15:0]                 ovr_nxt;
  logic [15:0]                 ph_nxt;
  logic [2:0]                  run_nxt;
  logic [2:0]                  pre_target;
  logic [lfw_pkg::IRQ_W-1:0]   ev;
  logic                        wr_mode;

  // --------------------------------------------------------------------------
  // Front-end synchronisation
  // --------------------------------------------------------------------------
  lfw_sync3 #(
    .W (lfw_pkg::FE_W)
  ) u_sync (
    .clk  (CLOCK),
    .rst  (RST),
    .din  ({DATA_BIT, SAMPLE_STROBE, LOWFREQ_OSCILLATOR_CLOCK, CARRIER_OUT,
            SLICER_LPF_TRIM, SLICER_OFFSET_TRIM, STRENGTH_THRESHOLD_OUT,
            BIAS_MONITOR, AMP_READY}),
    .dout (fe)
  );

  assign fe_vec = {fe[lfw_pkg::FE_AMP],
                   fe[lfw_pkg::FE_BIAS],
                   fe[lfw_pkg::FE_THRESH],
                   q.mode[lfw_pkg::MODE_TRIM_BIT] ? fe[lfw_pkg::FE_LPF_TRIM]
                                                  : fe[lfw_pkg::FE_OFS_TRIM],
                   fe[lfw_pkg::FE_CARRIER],
                   fe[lfw_pkg::FE_OSC],
                   fe[lfw_pkg::FE_SAMPLE],
                   fe[lfw_pkg::FE_DATA]};

  assign state_vec = {q.fl_ready, q.fl_sync & q.fl_wake, q.fl_wake, q.fl_sync,
                      q.fl_head, q.fl_pre, q.fl_abort,
                      q.div[lfw_pkg::DIV_W-1]};

  // --------------------------------------------------------------------------
  // Timing limits
  // --------------------------------------------------------------------------
  assign ovr_lim = 16'((16'(q.sniff_lim[lfw_pkg::OVR_LSB +: lfw_pkg::OVR_W])
                        * 16'(lfw_pkg::OVR_MULT) + 16'(lfw_pkg::OVR_ADD))
                       * 16'(lfw_pkg::TICKS_PER_UNIT));
  assign pre_lim = 16'(16'(q.sniff_lim[lfw_pkg::PRE_W-1:0])
                       * 16'(lfw_pkg::PRE_MULT * lfw_pkg::TICKS_PER_UNIT));
  assign cd_lim  = 16'((16'(q.cd_cfg[lfw_pkg::CD_W-1:0]) + 16'h0001)
                       * 16'(lfw_pkg::CD_MULT));
  assign pre_target = q.cd_cfg[lfw_pkg::PREVALID_BIT] ? lfw_pkg::PRE_RUN_SHORT
                                                      : lfw_pkg::PRE_RUN_LONG;

  assign ovr_nxt  = q.ovr_cnt + 16'h0001;
  assign ph_nxt   = q.ph_cnt + 16'h0001;
  assign run_nxt  = q.run + 3'h1;
  assign tick     = fe[lfw_pkg::FE_OSC] & ~q.osc_q;
  assign s_edge   = fe[lfw_pkg::FE_SAMPLE] & ~q.samp_q;
  assign d_edge   = fe[lfw_pkg::FE_DATA] ^ q.data_q;
  assign smp_bit  = fe[lfw_pkg::FE_DATA];
  assign sniffing = (q.state == lfw_pkg::S_CARR) || (q.state == lfw_pkg::S_PRE)
                    || (q.state == lfw_pkg::S_HEAD);

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  assign idx             = AVS_ADDRESS[lfw_pkg::ADDR_W-1:2];
  assign req             = AVS_READ | AVS_WRITE;
  assign acc             = req & q.ack;
  assign AVS_WAITREQUEST = req & ~q.ack;
  assign AVS_READDATA    = {24'h00_0000, q.rdata};
  assign wr_mode         = acc & AVS_WRITE & AVS_BYTEENABLE[0] & (idx == lfw_pkg::IDX_MODE);
  assign IRQ             = |(q.irq_stat & q.irq_mask);

  always_comb begin
    unique case (idx)
      lfw_pkg::IDX_FE_STATUS: rmux = fe_vec;
      lfw_pkg::IDX_RX_BYTE:   rmux = q.rx_byte;
      lfw_pkg::IDX_BIT_WIDTH: rmux = {q.fl_wake, q.width_reg};
      lfw_pkg::IDX_STATE:     rmux = state_vec;
      lfw_pkg::IDX_MODE:      rmux = q.mode;
      lfw_pkg::IDX_IRQ_STAT:  rmux = {4'h0, q.irq_stat};
      lfw_pkg::IDX_IRQ_MASK:  rmux = {4'h0, q.irq_mask};
      default:                rmux = lfw_pkg::RST_BYTE;
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    d      = q;
    ev     = '0;
    d.ack  = req & ~q.ack;
    d.osc_q  = fe[lfw_pkg::FE_OSC];
    d.samp_q = fe[lfw_pkg::FE_SAMPLE];
    d.data_q = fe[lfw_pkg::FE_DATA];
    if (req && !q.ack && AVS_READ) begin
      d.rdata = rmux;
    end
    if (tick) begin
      d.div = q.div + 5'h01;
    end

    // Clears first, so that a set in the same cycle wins.
    if (acc && AVS_READ && idx == lfw_pkg::IDX_IRQ_STAT) begin
      d.irq_stat = '0;
    end
    if (acc && AVS_READ && idx == lfw_pkg::IDX_RX_BYTE) begin
      d.fl_ready = 1'b0;
    end
    if (acc && AVS_WRITE && AVS_BYTEENABLE[0]) begin
      unique case (idx)
        lfw_pkg::IDX_SNIFF:    d.sniff_lim = AVS_WRITEDATA[7:0];
        lfw_pkg::IDX_CARRIER:  d.cd_cfg    = AVS_WRITEDATA[4:0];
        lfw_pkg::IDX_MODE:     d.mode      = AVS_WRITEDATA[7:0];
        lfw_pkg::IDX_IRQ_MASK: d.irq_mask  = AVS_WRITEDATA[lfw_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end

    // Width of one data bit in oscillator cycles, saturating.
    if (d_edge) begin
      d.width_reg = q.width_cnt;
      d.width_cnt = '0;
    end else if (tick && q.width_cnt != lfw_pkg::WIDTH_MAX) begin
      d.width_cnt = q.width_cnt + 7'h01;
    end

    if (q.state != lfw_pkg::S_IDLE) begin
      if (SYNC_MATCH) begin
        d.fl_sync = 1'b1;
      end
      if (WAKE_MATCH && !q.fl_wake) begin
        d.fl_wake = 1'b1;
        ev[lfw_pkg::IRQ_WAKE] = 1'b1;
      end
    end

    if (sniffing && tick) begin
      d.ovr_cnt = ovr_nxt;
    end

    unique case (q.state)
      lfw_pkg::S_IDLE: ;
      lfw_pkg::S_CARR: begin
        if (!fe[lfw_pkg::FE_CARRIER]) begin
          d.ph_cnt = '0;
        end else if (tick) begin
          d.ph_cnt = ph_nxt;
          if (ph_nxt == cd_lim) begin
            d.state  = lfw_pkg::S_PRE;
            d.ph_cnt = '0;
            d.run    = '0;
          end
        end
      end
      lfw_pkg::S_PRE: begin
        if (tick) begin
          d.ph_cnt = ph_nxt;
        end
        if (tick && pre_lim != 16'h0000 && ph_nxt == pre_lim) begin
          d.state    = lfw_pkg::S_IDLE;
          d.fl_abort = 1'b1;
          ev[lfw_pkg::IRQ_ABORT] = 1'b1;
        end else if (s_edge) begin
          d.last_bit = smp_bit;
          // Alternating symbols extend the run; a repeat restarts it.
          d.run = (q.run == 3'h0 || smp_bit != q.last_bit) ? run_nxt : 3'h1;
          if ((q.run == 3'h0 || smp_bit != q.last_bit) && run_nxt == pre_target) begin
            d.state  = lfw_pkg::S_HEAD;
            d.fl_pre = 1'b1;
            d.run    = '0;
            ev[lfw_pkg::IRQ_PRE] = 1'b1;
          end
        end
      end
      lfw_pkg::S_HEAD: begin
        if (s_edge) begin
          d.run = smp_bit ? run_nxt : 3'h0;
          if (smp_bit && run_nxt == lfw_pkg::HEAD_RUN) begin
            d.state   = lfw_pkg::S_DATA;
            d.fl_head = 1'b1;
            d.bitn    = '0;
          end
        end
      end
      lfw_pkg::S_DATA: begin
        if (!fe[lfw_pkg::FE_CARRIER]) begin
          d.state = lfw_pkg::S_IDLE;
        end else if (s_edge) begin
          d.shift = {q.shift[6:0], smp_bit};
          d.bitn  = q.bitn + 3'h1;
          if (q.bitn == lfw_pkg::LAST_BIT_IDX) begin
            d.rx_byte  = {q.shift[6:0], smp_bit};
            d.fl_ready = 1'b1;
            ev[lfw_pkg::IRQ_BYTE] = 1'b1;
          end
        end
      end
      default: d.state = lfw_pkg::S_IDLE;
    endcase

    // The overall limit outranks every phase of the sniff.
    if (sniffing && tick && ovr_nxt == ovr_lim) begin
      d.state    = lfw_pkg::S_IDLE;
      d.fl_abort = 1'b1;
      ev[lfw_pkg::IRQ_ABORT] = 1'b1;
    end

    // A mode write arms or stops the receiver and overrides the sequencer.
    if (wr_mode) begin
      if (AVS_WRITEDATA[lfw_pkg::MODE_EN_BIT]) begin
        d.state    = lfw_pkg::S_CARR;
        d.ovr_cnt  = '0;
        d.ph_cnt   = '0;
        d.run      = '0;
        d.fl_sync  = 1'b0;
        d.fl_wake  = 1'b0;
        d.fl_head  = 1'b0;
        d.fl_pre   = 1'b0;
        d.fl_abort = 1'b0;
      end else begin
        d.state = lfw_pkg::S_IDLE;
      end
    end

    d.irq_stat = d.irq_stat | ev;
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      q       <= '0;
      q.state <= lfw_pkg::S_IDLE;
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  property p_fe_read;
    (acc && AVS_READ && idx == lfw_pkg::IDX_FE_STATUS)
      |-> (AVS_READDATA[7] == $past(fe[lfw_pkg::FE_AMP]))
          && (AVS_READDATA[6] == $past(fe[lfw_pkg::FE_BIAS]));
  endproperty
  a_fe_read: assert property (p_fe_read) else $error("front-end readback wrong");

  property p_thresh;
    fe_vec[5] == fe[lfw_pkg::FE_THRESH];
  endproperty
  a_thresh: assert property (p_thresh) else $error("threshold bit wrong");

  property p_slicer;
    fe_vec[4] == (q.mode[lfw_pkg::MODE_TRIM_BIT] ? fe[lfw_pkg::FE_LPF_TRIM]
                                                 : fe[lfw_pkg::FE_OFS_TRIM]);
  endproperty
  a_slicer: assert property (p_slicer) else $error("slicer bit wrong");

  property p_width;
    d_edge |=> (q.width_reg == $past(q.width_cnt)) && (q.width_cnt == 7'h00);
  endproperty
  a_width: assert property (p_width) else $error("bit width not captured");

  property p_overall;
    (sniffing && tick && ovr_nxt == ovr_lim && !wr_mode)
      |=> (q.state == lfw_pkg::S_IDLE) && q.fl_abort && q.irq_stat[lfw_pkg::IRQ_ABORT];
  endproperty
  a_overall: assert property (p_overall) else $error("overall abort missing");

  property p_preamble_to;
    (q.state == lfw_pkg::S_PRE && tick && pre_lim != 16'h0000 && ph_nxt == pre_lim
     && !wr_mode) |=> q.fl_abort && (q.state == lfw_pkg::S_IDLE);
  endproperty
  a_preamble_to: assert property (p_preamble_to) else $error("preamble abort missing");

  property p_pre_valid;
    ($rose(q.fl_pre) && !q.fl_abort && !$past(wr_mode))
      |-> ($past(run_nxt) == $past(pre_target)) && (q.state == lfw_pkg::S_HEAD);
  endproperty
  a_pre_valid: assert property (p_pre_valid) else $error("preamble count wrong");

  property p_carrier_len;
    (q.state == lfw_pkg::S_CARR && tick && fe[lfw_pkg::FE_CARRIER] && ph_nxt == cd_lim
     && !wr_mode && !(ovr_nxt == ovr_lim)) |=> (q.state == lfw_pkg::S_PRE) && (q.ph_cnt == 16'h0000);
  endproperty
  a_carrier_len: assert property (p_carrier_len) else $error("carrier detect wrong");

  property p_byte;
    (q.state == lfw_pkg::S_DATA && fe[lfw_pkg::FE_CARRIER] && s_edge
     && q.bitn == lfw_pkg::LAST_BIT_IDX && !wr_mode)
      |=> q.fl_ready && (q.rx_byte == {$past(q.shift[6:0]), $past(smp_bit)});
  endproperty
  a_byte: assert property (p_byte) else $error("received byte not stored");

  property p_wait;
    (req && !q.ack) |-> AVS_WAITREQUEST ##1 (!req || !AVS_WAITREQUEST);
  endproperty
  a_wait: assert property (p_wait) else $error("wait state wrong");

  cv_byte:  cover property ($rose(q.fl_ready));
  cv_abort: cover property ($rose(q.fl_abort));
  cv_pre:   cover property ($rose(q.fl_pre));
  cv_irq:   cover property ($rose(IRQ));

endmodule : lfw_rx_status

// ===== dv/lfw_fe_model.sv
// Purpose: Behavioural LF front end: oscillator, carrier, sample strobe and data bits.
// Assumes: One bit lasts 16 clocks and is sampled in its second half.
// Notes:   When not running and not busy, the pins follow the bench's test levels.
`timescale 1ns/1ps
module lfw_fe_model (
  input  wire logic        CLOCK,
  input  wire logic        RUN,
  input  wire logic        GO,
  input  wire logic [16:0] BITS,
  input  wire logic [3:0]  TST,
  output logic             OSC,
  output logic             CARRIER,
  output logic             SAMPLE,
  output logic             DATA,
  output logic             DONE
);
  logic [8:0] cnt_q  = '0;
  logic [2:0] div_q  = '0;
  logic       busy_q = 1'b0;
  logic       last_q = 1'b0;
  logic       bit_w;
  assign bit_w = BITS[5'd16 - cnt_q[8:4]];
  always_ff @(posedge CLOCK) begin
    div_q <= div_q + 3'h1;
    if (GO && !busy_q) begin
      busy_q <= 1'b1;
      cnt_q  <= '0;
    end else if (busy_q) begin
      cnt_q  <= cnt_q + 9'h001;
      last_q <= bit_w;
      busy_q <= (cnt_q != 9'h10f);
    end
  end
  // While running, a released data line shows the inverse of its last bit, never a held value.
  assign OSC     = RUN ? div_q[2] : TST[1];
  assign CARRIER = RUN ? 1'b1 : TST[0];
  assign SAMPLE  = busy_q ? cnt_q[3] : (RUN ? 1'b0 : TST[2]);
  assign DATA    = busy_q ? bit_w : (RUN ? !last_q : TST[3]);
  assign DONE    = !busy_q;
endmodule : lfw_fe_model

// ===== dv/lfw_rx_status_test.sv
// Purpose: Self-checking bench for the LF receiver timing and status block.
// Assumes: Oscillator tick is 8 clocks, so every timing figure is counted in ticks.
// Notes:   Sync match is tied low; wake match is pulsed once after the frame.
`timescale 1ns/1ps
module lfw_rx_status_test;
  logic        CLOCK = 0, RST = 1, rd_q = 0, wr_q = 0, run = 0, go = 0, wake = 0;
  logic [9:0]  adr   = '0;
  logic [31:0] wd    = '0;
  logic [3:0]  be    = 4'hf, tst = '0;
  logic [4:0]  fe    = '0;
  logic [16:0] bits  = {6'h2a, 3'h7, 8'ha5};
  logic [31:0] rdata;
  logic        wreq, irq, osc, car, smp, dat, done;
  logic [7:0]  v;
  int          err_count = 0, num_checks = 0, cyc = 0;
  // Rows: {mode bit six, front-end inputs, expected status byte}.
  logic [17:0] rows [9] = '{18'h0_0180, 18'h0_0240, 18'h0_0420, 18'h0_0810, 18'h2_0800,
                            18'h2_1010, 18'h0_1000, 18'h1_e00f, 18'h1_55a5};
  always #10 CLOCK = ~CLOCK;
  lfw_rx_status dut (.CLOCK(CLOCK), .RST(RST), .AVS_ADDRESS(adr), .AVS_READ(rd_q),
    .AVS_WRITE(wr_q), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wreq), .AMP_READY(fe[0]), .BIAS_MONITOR(fe[1]),
    .STRENGTH_THRESHOLD_OUT(fe[2]), .SLICER_OFFSET_TRIM(fe[3]), .SLICER_LPF_TRIM(fe[4]),
    .CARRIER_OUT(car), .LOWFREQ_OSCILLATOR_CLOCK(osc), .SAMPLE_STROBE(smp),
    .DATA_BIT(dat), .SYNC_MATCH(1'b0), .WAKE_MATCH(wake), .IRQ(irq));
  lfw_fe_model fem (.CLOCK(CLOCK), .RUN(run), .GO(go), .BITS(bits), .TST(tst), .OSC(osc),
    .CARRIER(car), .SAMPLE(smp), .DATA(dat), .DONE(done));
  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic acc(input logic w, input logic [7:0] i, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge CLOCK);
    adr  <= {i, 2'b00};
    wd   <= {24'h00_0000, d};
    wr_q <= w;
    rd_q <= !w;
    do @(posedge CLOCK); while (wreq !== 1'b0);
    q = rdata[7:0];
    wr_q <= 1'b0;
    rd_q <= 1'b0;
  endtask : acc
  task automatic chk(input logic [7:0] e, input logic [7:0] s, input string n);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] i, input logic [7:0] e, input logic [7:0] m,
                     input string n);
    logic [7:0] q;
    acc(1'b0, i, 8'h00, q);
    chk(e, q & m, n);
  endtask : rdc
  task automatic end_sim;
    if (err_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  // --------------------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge CLOCK);
    RST <= 1'b0;
    foreach (rows[k]) begin
      acc(1'b1, lfw_pkg::IDX_MODE, {1'b0, rows[k][17], 6'h00}, v);
      fe  <= rows[k][12:8];
      tst <= rows[k][16:13];
      repeat (10) @(posedge CLOCK);
      rdc(lfw_pkg::IDX_FE_STATUS, rows[k][7:0], 8'hff, "fe_status");
    end
    rdc(lfw_pkg::IDX_RX_BYTE, lfw_pkg::RST_BYTE, 8'hff, "rx_byte_reset");
    rdc(lfw_pkg::IDX_BIT_WIDTH, 8'h00, 8'hff, "bit_width_reset");
    rdc(lfw_pkg::IDX_SNIFF, 8'h00, 8'hff, "write_only_read");
    rdc(8'h10, 8'h00, 8'hff, "unmapped_read");
    be <= 4'he;
    acc(1'b1, lfw_pkg::IDX_IRQ_MASK, 8'hff, v);
    be <= 4'hf;
    rdc(lfw_pkg::IDX_IRQ_MASK, 8'h00, 8'hff, "mask_lane_off");
    // Five oscillator rises between two data edges must read back as a width of five.
    repeat (5) begin
      tst[1] <= 1'b0;
      repeat (4) @(posedge CLOCK);
      tst[1] <= 1'b1;
      repeat (4) @(posedge CLOCK);
    end
    tst[3] <= 1'b0;
    repeat (8) @(posedge CLOCK);
    rdc(lfw_pkg::IDX_BIT_WIDTH, 8'h05, 8'hff, "bit_width");
    // A full frame: preamble, head, then one data byte.
    acc(1'b1, lfw_pkg::IDX_CARRIER, 8'h10, v);
    acc(1'b1, lfw_pkg::IDX_SNIFF, 8'h00, v);
    acc(1'b1, lfw_pkg::IDX_IRQ_MASK, 8'h01, v);
    run <= 1'b1;
    acc(1'b1, lfw_pkg::IDX_MODE, 8'h01, v);
    repeat (300) @(posedge CLOCK);
    go <= 1'b1;
    @(posedge CLOCK);
    go <= 1'b0;
    do @(posedge CLOCK); while (done !== 1'b1);
    repeat (20) @(posedge CLOCK);
    chk(8'h01, {7'h00, irq}, "irq_byte");
    rdc(lfw_pkg::IDX_STATE, 8'h8c, 8'h8c, "state_frame");
    rdc(lfw_pkg::IDX_RX_BYTE, 8'ha5, 8'hff, "rx_byte");
    rdc(lfw_pkg::IDX_STATE, 8'h00, 8'h80, "ready_cleared");
    rdc(lfw_pkg::IDX_IRQ_STAT, 8'h01, 8'h01, "irq_stat_byte");
    rdc(lfw_pkg::IDX_IRQ_STAT, 8'h00, 8'h01, "irq_stat_cleared");
    @(posedge CLOCK);
    chk(8'h00, {7'h00, irq}, "irq_cleared");
    wake <= 1'b1;
    @(posedge CLOCK);
    wake <= 1'b0;
    rdc(lfw_pkg::IDX_BIT_WIDTH, 8'h80, 8'h80, "wake_flag");
    rdc(lfw_pkg::IDX_STATE, 8'h20, 8'h20, "wake_state");
    // Preamble limit of 512 ticks with no preamble sent: abort well before the overall limit.
    acc(1'b1, lfw_pkg::IDX_SNIFF, 8'h01, v);
    acc(1'b1, lfw_pkg::IDX_MODE, 8'h00, v);
    acc(1'b1, lfw_pkg::IDX_MODE, 8'h01, v);
    repeat (3950) @(posedge CLOCK);
    rdc(lfw_pkg::IDX_STATE, 8'h00, 8'h02, "pre_abort_early");
    repeat (350) @(posedge CLOCK);
    rdc(lfw_pkg::IDX_STATE, 8'h02, 8'h06, "pre_abort_late");
    rdc(lfw_pkg::IDX_IRQ_STAT, 8'h04, 8'h04, "irq_stat_pre_abort");
    acc(1'b1, lfw_pkg::IDX_SNIFF, 8'h00, v);
    // Carrier without preamble: the overall limit of 1028 ticks must abort.
    acc(1'b1, lfw_pkg::IDX_MODE, 8'h00, v);
    acc(1'b1, lfw_pkg::IDX_MODE, 8'h01, v);
    repeat (8000) @(posedge CLOCK);
    rdc(lfw_pkg::IDX_STATE, 8'h00, 8'h02, "abort_early");
    repeat (500) @(posedge CLOCK);
    rdc(lfw_pkg::IDX_STATE, 8'h02, 8'h02, "abort_late");
    chk(8'h00, {7'h00, irq}, "irq_masked");
    rdc(lfw_pkg::IDX_IRQ_STAT, 8'h04, 8'h04, "irq_stat_abort");
    end_sim();
  end
endmodule : lfw_rx_status_test
